// >>> rtl/ics_client.sv
// two-wire bus client: address match, byte shifting, status flags
// assumes: clk_in 100 MHz, scl/sda from pins (synchronised here),
// host_enable_in from logic on clk_in, register port on clk_in
`include "ics_map.svh"

// Contract
// - finish command: ack if writing, await start
// - response when writing: ack, receive next byte
// - response when reading: ack-then-data or send-byte
// - ack choice written with command applies first
// - byte done flag on byte end, also after a lost high bit
// - data access or command clears both flags
// - address match or stop sets address flag
// - hold SCL low after address/data byte until continued
// - status bit 4 holds host acknowledge
// - collision on lost high bit or address NACK
// - collision cleared by write one, start
// - illegal start/stop sets bus error, W1C
// - bus errors only with host logic enabled
// - status bit 1 holds address direction
// - cause bit: 0 stop, 1 address
// - match against own address bits 7:1
// - own address bit 0 adds general call
// - smart mode data read continues with ack
// - mask bits make positions always match
// - mask-enable makes mask a second address
// - accept-all mode matches every address
// - without smart mode, wait for command
// - data write performs no acknowledge
module ics_client (
	input  wire logic             clk_in,         // 100 MHz clock
	input  wire logic             rst_b_in,       // async reset, low
	input  wire ics_pkg::ics_req_t bus_req_in,    // register request
	output logic [7:0]            rdata_out,      // read data, +1 cycle
	input  wire logic             host_enable_in, // host logic enabled
	input  wire logic             scl_in,         // SCL pin level
	output logic                  scl_out,        // SCL drive level
	output logic                  scl_oe_out,     // SCL pulled low
	input  wire logic             sda_in,         // SDA pin level
	output logic                  sda_out,        // SDA drive level
	output logic                  sda_oe_out      // SDA pulled low
);
	ics_pkg::ics_regs_t r_ff;
	ics_pkg::ics_regs_t nxt_r;

	// address compare against own, second or masked address
	function automatic logic ics_match(
		input logic [6:0] a,
		input logic [7:0] own,
		input logic [7:0] msk,
		input logic       all
	);
		logic hit;
		hit = 1'b0;
		if (all) begin
			hit = 1'b1;
		end else if (own[0] && a == `ICS_GCALL) begin
			hit = 1'b1;
		end else if (msk[0]) begin
			hit = (a == own[7:1]) || (a == msk[7:1]);
		end else begin
			hit = ((a ^ own[7:1]) & ~msk[7:1]) == 7'h00;
		end
		return hit;
	endfunction

	// write strobe to one register offset
	function automatic logic ics_wr_at(
		input ics_pkg::ics_req_t q,
		input logic [3:0]        ofs
	);
		return q.wr && q.addr == ofs;
	endfunction

	// read strobe to one register offset
	function automatic logic ics_rd_at(
		input ics_pkg::ics_req_t q,
		input logic [3:0]        ofs
	);
		return q.rd && q.addr == ofs;
	endfunction

	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic       stop_seen;
	logic       cmd_wr;
	logic [1:0] cmd;
	logic       ack_now;
	logic       data_rd;
	logic       data_wr;
	logic       go_finish;
	logic       go_resp;
	logic       mid_byte;
	logic [7:0] status;

	// line edges and bus conditions from the synchronised pins
	assign scl_rise   = r_ff.scl_s[1] & ~r_ff.scl_s[2];
	assign scl_fall   = ~r_ff.scl_s[1] & r_ff.scl_s[2];
	assign start_seen = r_ff.scl_s[1] & r_ff.scl_s[2] &
		r_ff.sda_s[2] & ~r_ff.sda_s[1];
	assign stop_seen  = r_ff.scl_s[1] & r_ff.scl_s[2] &
		~r_ff.sda_s[2] & r_ff.sda_s[1];

	// register port decode
	assign cmd_wr  = ics_wr_at(bus_req_in, `ICS_CTL2_OFS);
	assign cmd     = bus_req_in.wdata[1:0];
	assign ack_now = cmd_wr ? bus_req_in.wdata[`ICS_ACK_BIT] : r_ff.ack;
	assign data_rd = ics_rd_at(bus_req_in, `ICS_DATA_OFS);
	assign data_wr = ics_wr_at(bus_req_in, `ICS_DATA_OFS);

	// continue triggers while SCL is held
	assign go_finish = cmd_wr && cmd == `ICS_CMD_FINISH;
	assign go_resp   = (cmd_wr && cmd == `ICS_CMD_RESPONSE) ||
		(r_ff.ctl1[`ICS_AUTO_ACK_BIT] && data_rd) ||
		(r_ff.ctl1[`ICS_AUTO_ACK_BIT] && data_wr && r_ff.dir &&
		!r_ff.hk);

	assign mid_byte = (r_ff.st == ics_pkg::ICS_ADDR ||
		r_ff.st == ics_pkg::ICS_RX || r_ff.st == ics_pkg::ICS_TX) &&
		r_ff.cnt != 4'h0;

	// status view; clock hold follows the hold state
	assign status = {r_ff.byte_done_flag, r_ff.addr_or_stop_flag,
		r_ff.st == ics_pkg::ICS_HOLD,
		r_ff.host_ack_seen, r_ff.drive_conflict_flag, r_ff.berr, r_ff.dir, r_ff.ap};

	// next state of the whole block
	always_comb begin
		nxt_r = r_ff;
		nxt_r.scl_s = {r_ff.scl_s[1:0], scl_in};
		nxt_r.sda_s = {r_ff.sda_s[1:0], sda_in};

		// register writes
		if (ics_wr_at(bus_req_in, `ICS_CTL1_OFS)) begin
			nxt_r.ctl1 = bus_req_in.wdata & `ICS_CTL1_WMASK;
		end
		if (cmd_wr) begin
			nxt_r.ack = bus_req_in.wdata[`ICS_ACK_BIT];
		end
		if (ics_wr_at(bus_req_in, `ICS_OWN_OFS)) begin
			nxt_r.own = bus_req_in.wdata;
		end
		if (ics_wr_at(bus_req_in, `ICS_MASK_OFS)) begin
			nxt_r.mask = bus_req_in.wdata;
		end
		if (data_wr) begin
			nxt_r.data = bus_req_in.wdata;
		end
		if (ics_wr_at(bus_req_in, `ICS_STATUS_OFS)) begin
			if (bus_req_in.wdata[`ICS_DIF_BIT]) begin
				nxt_r.byte_done_flag = 1'b0;
			end
			if (bus_req_in.wdata[`ICS_ADDR_OR_STOP_FLAG_BIT]) begin
				nxt_r.addr_or_stop_flag = 1'b0;
			end
			if (bus_req_in.wdata[`ICS_DRIVE_CONFLICT_FLAG_BIT]) begin
				nxt_r.drive_conflict_flag = 1'b0;
			end
			if (bus_req_in.wdata[`ICS_BERR_BIT]) begin
				nxt_r.berr = 1'b0;
			end
		end

		// data access or command clears both interrupt flags
		if (data_rd || data_wr || cmd_wr) begin
			nxt_r.byte_done_flag  = 1'b0;
			nxt_r.addr_or_stop_flag = 1'b0;
		end

		// illegal start/stop placement, only with host logic on
		if (host_enable_in && (((start_seen || stop_seen) && mid_byte) ||
			(stop_seen && r_ff.st == ics_pkg::ICS_ADDR))) begin
			nxt_r.berr = 1'b1;
		end

		// byte level sequencer
		case (r_ff.st)
			ics_pkg::ICS_ADDR: begin
				if (scl_rise) begin
					nxt_r.sh  = {r_ff.sh[6:0], r_ff.sda_s[1]};
					nxt_r.cnt = r_ff.cnt + 4'h1;
				end
				if (scl_fall && r_ff.cnt == `ICS_BYTE_BITS) begin
					nxt_r.cnt = 4'h0;
					if (ics_match(r_ff.sh[7:1], r_ff.own, r_ff.mask,
						r_ff.ctl1[`ICS_ALL_ADDR_BIT])) begin
						nxt_r.addr_or_stop_flag = 1'b1;
						nxt_r.ap   = 1'b1;
						nxt_r.dir  = r_ff.sh[0];
						nxt_r.hk   = 1'b1;
						nxt_r.sel  = 1'b1;
						nxt_r.st   = ics_pkg::ICS_HOLD;
					end else begin
						nxt_r.st = ics_pkg::ICS_WAIT;
					end
				end
			end
			ics_pkg::ICS_HOLD: begin
				// stays held until a command or smart access
				if (go_finish || go_resp) begin
					nxt_r.cnt = 4'h0;
					if (r_ff.hk && ack_now) begin
						nxt_r.drive_conflict_flag    = 1'b1;
						nxt_r.st      = ics_pkg::ICS_ACK;
						nxt_r.nx      = ics_pkg::ICS_WAIT;
					end else if (r_ff.dir && go_finish) begin
						nxt_r.st = ics_pkg::ICS_WAIT;
					end else if (r_ff.hk && r_ff.dir) begin
						nxt_r.st      = ics_pkg::ICS_ACK;
						nxt_r.nx      = ics_pkg::ICS_HOLD;
						nxt_r.sda_drv = ~ack_now;
					end else if (r_ff.dir) begin
						// transmit the byte; no ack action here
						nxt_r.st      = ics_pkg::ICS_TX;
						nxt_r.sh      = nxt_r.data;
						nxt_r.txfail  = 1'b0;
						nxt_r.sda_drv = ~nxt_r.data[7];
					end else begin
						nxt_r.st      = ics_pkg::ICS_ACK;
						nxt_r.nx      = go_finish ? ics_pkg::ICS_WAIT :
							ics_pkg::ICS_RX;
						nxt_r.sda_drv = ~ack_now;
					end
				end
			end
			ics_pkg::ICS_ACK: begin
				if (scl_rise) begin
					nxt_r.cnt = 4'h1;
				end
				if (scl_fall && r_ff.cnt == 4'h1) begin
					nxt_r.cnt     = 4'h0;
					nxt_r.sda_drv = 1'b0;
					nxt_r.st      = r_ff.nx;
					if (r_ff.nx == ics_pkg::ICS_HOLD) begin
						nxt_r.byte_done_flag = 1'b1;
						nxt_r.hk  = 1'b0;
					end
				end
			end
			ics_pkg::ICS_RX: begin
				if (scl_rise) begin
					nxt_r.sh  = {r_ff.sh[6:0], r_ff.sda_s[1]};
					nxt_r.cnt = r_ff.cnt + 4'h1;
				end
				if (scl_fall && r_ff.cnt == `ICS_BYTE_BITS) begin
					nxt_r.cnt  = 4'h0;
					nxt_r.data = r_ff.sh;
					nxt_r.byte_done_flag  = 1'b1;
					nxt_r.hk   = 1'b0;
					nxt_r.st   = ics_pkg::ICS_HOLD;
				end
			end
			ics_pkg::ICS_TX: begin
				if (scl_rise) begin
					nxt_r.cnt = r_ff.cnt + 4'h1;
					if (r_ff.sh[7] && !r_ff.sda_s[1] && !r_ff.txfail) begin
						nxt_r.drive_conflict_flag   = 1'b1;
						nxt_r.txfail = 1'b1;
					end
				end
				if (scl_fall) begin
					nxt_r.sh = {r_ff.sh[6:0], 1'b0};
					if (r_ff.cnt == `ICS_BYTE_BITS) begin
						nxt_r.st = ics_pkg::ICS_HACK;
					end
				end
				nxt_r.sda_drv = nxt_r.st == ics_pkg::ICS_TX &&
					!nxt_r.sh[7] && !nxt_r.txfail;
			end
			ics_pkg::ICS_HACK: begin
				if (scl_rise) begin
					nxt_r.host_ack_seen = r_ff.sda_s[1];
					nxt_r.cnt   = `ICS_ACK_SLOT;
				end
				if (scl_fall && r_ff.cnt == `ICS_ACK_SLOT) begin
					nxt_r.cnt = 4'h0;
					nxt_r.byte_done_flag = 1'b1;
					nxt_r.hk  = 1'b0;
					nxt_r.st  = ics_pkg::ICS_HOLD;
				end
			end
			ics_pkg::ICS_IDLE, ics_pkg::ICS_WAIT: begin
				nxt_r.sda_drv = 1'b0;
			end
			default: begin
				nxt_r.st = ics_pkg::ICS_IDLE;
			end
		endcase

		// start or repeated start restarts address reception
		if (start_seen) begin
			nxt_r.st      = ics_pkg::ICS_ADDR;
			nxt_r.cnt     = 4'h0;
			nxt_r.sel     = 1'b0;
			nxt_r.sda_drv = 1'b0;
			nxt_r.drive_conflict_flag    = 1'b0;
		end

		// stop ends the transaction; flagged only when addressed
		if (stop_seen) begin
			if (r_ff.sel && r_ff.ctl1[`ICS_STOP_EN_BIT]) begin
				nxt_r.addr_or_stop_flag = 1'b1;
				nxt_r.ap   = 1'b0;
			end
			nxt_r.st      = ics_pkg::ICS_IDLE;
			nxt_r.sel     = 1'b0;
			nxt_r.sda_drv = 1'b0;
		end

		// disabled client leaves both lines released
		if (!r_ff.ctl1[`ICS_ENABLE_BIT]) begin
			nxt_r.st      = ics_pkg::ICS_IDLE;
			nxt_r.sel     = 1'b0;
			nxt_r.sda_drv = 1'b0;
		end

		// read data, valid only in the cycle after the strobe
		nxt_r.rdata = 8'h00;
		if (bus_req_in.rd) begin
			case (bus_req_in.addr)
				`ICS_CTL1_OFS:   nxt_r.rdata = r_ff.ctl1;
				`ICS_CTL2_OFS:   nxt_r.rdata = {5'h00, r_ff.ack, 2'h0};
				`ICS_STATUS_OFS: nxt_r.rdata = status;
				`ICS_OWN_OFS:    nxt_r.rdata = r_ff.own;
				`ICS_DATA_OFS:   nxt_r.rdata = r_ff.data;
				`ICS_MASK_OFS:   nxt_r.rdata = r_ff.mask;
				default:         nxt_r.rdata = 8'h00;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// pin and port outputs
	assign rdata_out  = r_ff.rdata;
	assign scl_out    = 1'b0;
	assign scl_oe_out = r_ff.st == ics_pkg::ICS_HOLD;
	assign sda_out    = 1'b0;
	assign sda_oe_out = r_ff.sda_drv;
endmodule

// >>> rtl/ics_map.svh
// register offsets, field positions, reset values and command codes
// assumes: included by the client block after its package
`ifndef ICS_MAP_SVH
`define ICS_MAP_SVH
// register offsets on the 4-bit register port
`define ICS_CTL1_OFS     4'h9
`define ICS_CTL2_OFS     4'ha
`define ICS_STATUS_OFS   4'hb
`define ICS_OWN_OFS      4'hc
`define ICS_DATA_OFS     4'hd
`define ICS_MASK_OFS     4'he
// client_control_one fields
`define ICS_STOP_EN_BIT  5
`define ICS_ALL_ADDR_BIT 2
`define ICS_AUTO_ACK_BIT 1
`define ICS_ENABLE_BIT   0
`define ICS_CTL1_WMASK   8'h27
// client_control_two fields
`define ICS_ACK_BIT      2
// client_status fields
`define ICS_DIF_BIT      7
`define ICS_ADDR_OR_STOP_FLAG_BIT     6
`define ICS_HOLD_BIT     5
`define ICS_HOST_ACK_SEEN_BIT    4
`define ICS_DRIVE_CONFLICT_FLAG_BIT     3
`define ICS_BERR_BIT     2
`define ICS_DIR_BIT      1
`define ICS_AP_BIT       0
// reset value shared by all registers
`define ICS_REG_RST      8'h00
// client_command_field codes
`define ICS_CMD_IDLE     2'h0
`define ICS_CMD_FINISH   2'h2
`define ICS_CMD_RESPONSE 2'h3
// general call address and bits per byte
`define ICS_GCALL        7'h00
`define ICS_BYTE_BITS    4'h8
`define ICS_ACK_SLOT     4'h9
`endif

// >>> rtl/ics_pkg.sv
// types of the client block: bus request, states, whole state record
// assumes: compiled before the client block
package ics_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ics_req_t;

	typedef enum logic [2:0] {
		ICS_IDLE = 3'b000,
		ICS_ADDR = 3'b001,
		ICS_HOLD = 3'b010,
		ICS_ACK  = 3'b011,
		ICS_RX   = 3'b100,
		ICS_TX   = 3'b101,
		ICS_HACK = 3'b110,
		ICS_WAIT = 3'b111
	} ics_state_t;

	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		ics_state_t st;
		ics_state_t nx;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] data;
		logic [7:0] ctl1;
		logic [7:0] own;
		logic [7:0] mask;
		logic       ack;
		logic       byte_done_flag;
		logic       addr_or_stop_flag;
		logic       host_ack_seen;
		logic       drive_conflict_flag;
		logic       berr;
		logic       dir;
		logic       ap;
		logic       hk;
		logic       sel;
		logic       txfail;
		logic       sda_drv;
		logic [7:0] rdata;
	} ics_regs_t;
endpackage

// >>> tb/ics_host.sv
// bus host model: start, stop and bits on an open-drain pair
// assumes: pull-ups on both wires, wire levels fed back here
module ics_host (
	input  wire logic scl_in,     // SCL wire level
	input  wire logic sda_in,     // SDA wire level
	output logic      scl_oe_out, // pulls SCL low
	output logic      sda_oe_out  // pulls SDA low
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int Q = 20; // quarter of the 80 ns bit
	// lines released at start
	initial begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
	end
	// release SCL, honour stretching, hold high
	task automatic clk_high();
		scl_oe_out = 1'b0;
		wait (scl_in === 1'b1);
		#(2*Q);
	endtask
	// start or repeated start, ends with SCL low
	task automatic start();
		sda_oe_out = 1'b0;
		#Q;
		clk_high();
		sda_oe_out = 1'b1;
		#(2*Q);
		scl_oe_out = 1'b1;
		#Q;
	endtask
	// stop, leaves both wires released
	task automatic stop();
		sda_oe_out = 1'b1;
		#Q;
		clk_high();
		sda_oe_out = 1'b0;
		#(2*Q);
	endtask
	// one bit out, wire sampled at end of high
	task automatic bit_io(input logic b, output logic r);
		sda_oe_out = ~b;
		#Q;
		clk_high();
		r = sda_in;
		scl_oe_out = 1'b1;
		#Q;
	endtask
	// byte msb first; send ff to read
	task automatic send(input logic [7:0] d, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
	endtask
endmodule

// >>> tb/ics_properties.sv
// checker for the client block, seen from its ports only
// assumes: bound to the client block from the bench top
`include "ics_map.svh"

module ics_properties (
	input wire logic              clk_in,     // block clock
	input wire logic              rst_b_in,   // async reset, low
	input wire ics_pkg::ics_req_t bus_req_in, // register request
	input wire logic [7:0]        rdata_out,  // read data
	input wire logic              scl_in,     // SCL wire
	input wire logic              scl_oe_out, // SCL pulled low
	input wire logic              sda_oe_out  // SDA pulled low
);
	logic rd_st;
	logic wr_c2;
	// status read and command write decodes
	assign rd_st = bus_req_in.rd && bus_req_in.addr == `ICS_STATUS_OFS;
	assign wr_c2 = bus_req_in.wr && bus_req_in.addr == `ICS_CTL2_OFS;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	sequence s_clr_rd;
		bus_req_in.wr && bus_req_in.addr == `ICS_STATUS_OFS
			&& bus_req_in.wdata[3:2] == 2'b11 ##2 rd_st;
	endsequence
	sequence s_cmd_rd;
		wr_c2 && bus_req_in.wdata[1] ##2 rd_st;
	endsequence
	sequence s_data_rd;
		(bus_req_in.rd || bus_req_in.wr)
			&& bus_req_in.addr == `ICS_DATA_OFS ##2 rd_st;
	endsequence
	property p_hold_bit;
		rd_st |=> rdata_out[5] == $past(scl_oe_out);
	endproperty
	property p_release;
		wr_c2 && bus_req_in.wdata[1] && scl_oe_out |-> ##[1:4] !scl_oe_out;
	endproperty
	property p_stretch_low;
		$rose(scl_oe_out) |-> !$past(scl_in);
	endproperty
	property p_sda_low;
		$rose(sda_oe_out) |-> !scl_in;
	endproperty
	property p_w1c;
		s_clr_rd |=> rdata_out[3:2] == 2'b00;
	endproperty
	property p_cmd_clr;
		s_cmd_rd |=> rdata_out[7:6] == 2'b00;
	endproperty
	property p_data_clr;
		s_data_rd |=> rdata_out[7:6] == 2'b00;
	endproperty
	property p_cmd_rd0;
		bus_req_in.rd && bus_req_in.addr == `ICS_CTL2_OFS
			|=> rdata_out[1:0] == 2'b00;
	endproperty
	a_hold_bit: assert property (p_hold_bit)
		else $error("hold bit differs from stretch");
	a_release: assert property (p_release)
		else $error("command left SCL held");
	a_stretch_low: assert property (p_stretch_low)
		else $error("stretch began with SCL high");
	a_sda_low: assert property (p_sda_low)
		else $error("SDA pulled while SCL high");
	a_w1c: assert property (p_w1c)
		else $error("write one left flag set");
	a_cmd_clr: assert property (p_cmd_clr)
		else $error("command left flags set");
	a_data_clr: assert property (p_data_clr)
		else $error("data access left flags set");
	a_cmd_rd0: assert property (p_cmd_rd0)
		else $error("command field read nonzero");
endmodule

// >>> tb/testbench.sv
// self-checking bench for the two-wire client block
// assumes: host model on the wires, register port driven here
`include "ics_map.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] ST = `ICS_STATUS_OFS;
	localparam logic [3:0] C2 = `ICS_CTL2_OFS;
	localparam logic [3:0] DA = `ICS_DATA_OFS;
	logic              clk_in;
	logic              rst_b_in;
	logic              host_en;
	ics_pkg::ics_req_t req;
	logic [7:0]        rdata;
	logic              scl_oe, sda_oe, h_scl, h_sda;
	logic              scl_o, sda_o;
	// open-drain wires: an enabled driver shows its own level
	wire               scl = !h_scl && (!scl_oe || scl_o);
	wire               sda = !h_sda && (!sda_oe || sda_o);
	int                bad_count = 0;
	int                tests_run = 0;
	int                cyc = 0;
	logic [7:0]        o, m, d, r, v;
	logic [6:0]        a;
	logic              k, e, al;

	ics_client i_ics_client (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.bus_req_in(req), .rdata_out(rdata), .host_enable_in(host_en),
		.scl_in(scl), .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_out(sda_oe));
	ics_host hm (.scl_in(scl), .sda_in(sda), .scl_oe_out(h_scl),
		.sda_oe_out(h_sda));

	// 100 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// cycle ceiling against hangs
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] x, s);
		tests_run++;
		if (s !== x) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic wr(input logic [3:0] ad, input logic [7:0] wd);
		@(posedge clk_in);
		req <= '{ad, wd, 1'b1, 1'b0};
		@(posedge clk_in);
		req <= '0;
		#1;
	endtask
	// read, then compare the masked answer in its cycle
	task automatic rchk(input string n, input logic [3:0] ad,
		input logic [7:0] mk, x);
		@(posedge clk_in);
		req <= '{ad, 8'h00, 1'b0, 1'b1};
		@(posedge clk_in);
		req <= '0;
		#1;
		chk(n, x, rdata & mk);
	endtask
	task automatic hold_wait();
		for (int i = 0; i < 40 && scl_oe !== 1'b1; i++)
			@(posedge clk_in);
	endtask
	// expected address match
	function automatic logic hit(input logic [6:0] ad,
		input logic [7:0] ow, mk, input logic all);
		hit = all
			|| (ow[0] && ad == 7'h00)
			|| (mk[0] && ad == mk[7:1])
			|| ((ad ~^ ow[7:1]) | (mk[0] ? 7'h00 : mk[7:1])) == 7'h7f;
	endfunction

	// main sequence
	initial begin
		req = '0;
		host_en = 1'b0;
		rst_b_in = 1'b0;
		void'($urandom(46200));
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1'b1;
		for (int i = 9; i < 15; i++)
			rchk("reset", i[3:0], 8'hff, 8'h00);
		wr(4'h0, 8'h5a);
		rchk("unmapped", 4'h0, 8'hff, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			o = $urandom;
			m = $urandom;
			r = $urandom;
			al = (i == 7);
			case (i % 4)
				0: a = o[7:1] ^ (m[7:1] & r[6:0]);
				1: a = m[7:1];
				2: a = 7'h00;
				default: a = r[6:0];
			endcase
			e = hit(a, o, m, al);
			wr(`ICS_OWN_OFS, o);
			wr(`ICS_MASK_OFS, m);
			wr(`ICS_CTL1_OFS, {5'h00, al, 2'h1});
			rchk("own", `ICS_OWN_OFS, 8'hff, o);
			hm.start();
			hm.send({a, 1'b0}, v);
			hold_wait();
			rchk("match", ST, 8'hfc, e ? 8'h60 : 8'h00);
			if (e)
				wr(C2, 8'h02);
			hm.bit_io(1'b1, k);
			chk("addr ack", {7'h00, ~e}, {7'h00, k});
			hm.stop();
		end
		$display("test match done");
		wr(`ICS_OWN_OFS, 8'h50);
		wr(`ICS_MASK_OFS, 8'h00);
		wr(`ICS_CTL1_OFS, 8'h03);
		hm.start();
		hm.send(8'h50, v);
		hold_wait();
		rchk("addr w", ST, 8'hff, 8'h61);
		wr(C2, 8'h03);
		hm.bit_io(1'b1, k);
		chk("ack w", 8'h00, {7'h00, k});
		for (int j = 0; j < 2; j++) begin
			d = $urandom;
			hm.send(d, v);
			hold_wait();
			rchk("dif w", ST, 8'hfe, 8'ha0);
			if (j == 0)
				rchk("data w", DA, 8'hff, d);
			else
				wr(C2, 8'h06);
			hm.bit_io(1'b1, k);
			chk("byte ack", {7'h00, j[0]}, {7'h00, k});
		end
		hm.stop();
		$display("test write done");
		wr(`ICS_CTL1_OFS, 8'h01);
		hm.start();
		hm.send(8'h51, v);
		hold_wait();
		rchk("addr r", ST, 8'hff, 8'h63);
		wr(C2, 8'h03);
		hm.bit_io(1'b1, k);
		chk("ack r", 8'h00, {7'h00, k});
		hold_wait();
		rchk("dif r", ST, 8'hfe, 8'ha2);
		d = $urandom;
		wr(DA, d);
		rchk("data clr", ST, 8'he0, 8'h20);
		wr(C2, 8'h03);
		hm.send(8'hff, v);
		chk("data r", d, v);
		hm.bit_io(1'b1, k);
		hold_wait();
		rchk("nack r", ST, 8'hfe, 8'hb2);
		wr(C2, 8'h02);
		rchk("cmd clr", ST, 8'hc0, 8'h00);
		hm.stop();
		$display("test read done");
		hm.start();
		hm.send(8'h50, v);
		hold_wait();
		wr(C2, 8'h06);
		hm.bit_io(1'b1, k);
		rchk("drive_conflict_flag", ST, 8'h08, 8'h08);
		hm.start();
		hm.stop();
		rchk("drive_conflict_flag clr", ST, 8'hec, 8'h00);
		@(posedge clk_in);
		host_en <= 1'b1;
		#1;
		hm.start();
		hm.stop();
		rchk("berr", ST, 8'h04, 8'h04);
		wr(ST, 8'h0c);
		rchk("berr clr", ST, 8'h0c, 8'h00);
		// read transfer whose high bit the host overrides
		hm.start();
		hm.send(8'h51, v);
		hold_wait();
		wr(C2, 8'h03);
		hm.bit_io(1'b1, k);
		hold_wait();
		wr(DA, 8'h80);
		wr(C2, 8'h03);
		hm.send(8'h00, v);
		hm.bit_io(1'b1, k);
		hold_wait();
		rchk("tx drive_conflict_flag", ST, 8'hfe, 8'hba);
		wr(C2, 8'h02);
		wr(ST, 8'h0c);
		rchk("drive_conflict_flag w1c", ST, 8'hcc, 8'h00);
		hm.stop();
		$display("test errors done");
		give_verdict();
	end
endmodule

bind ics_client ics_properties i_props (.clk_in(clk_in),
	.rst_b_in(rst_b_in), .bus_req_in(bus_req_in), .rdata_out(rdata_out),
	.scl_in(scl_in), .scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out));
